// *** pkg/gcr_pkg.sv ***
/*
  Shared constants, types and decode tables for the rate-sensor configuration bank.
  Assumes a single 40 MHz clock and a host register port already decoded to
  address, data and one-cycle strobes by the serial front end.
*/
package gcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam longint CLK_HZ = 40_000_000;
  localparam longint SRST_WAIT_MS = 30;
  localparam longint DRDY_HOLD_MIN_US = 280;
  localparam longint ODR_MAX_HZ = 2000;
  localparam int unsigned SRST_WAIT_CYCLES = int'((SRST_WAIT_MS * CLK_HZ) / 1000);
  // Least hold rounds up to whole cycles
  localparam int unsigned DRDY_HOLD_CYCLES =
    int'((DRDY_HOLD_MIN_US * CLK_HZ + 999_999) / 1_000_000);
  localparam int unsigned ODR_BASE_CYCLES = int'(CLK_HZ / ODR_MAX_HZ);
  localparam int TMR_W = 21;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_STAT = 8'h0A;
  localparam logic [7:0] ADDR_RANGE = 8'h0F;
  localparam logic [7:0] ADDR_ODR = 8'h10;
  localparam logic [7:0] ADDR_PM = 8'h11;
  localparam logic [7:0] ADDR_SRST = 8'h14;
  localparam logic [7:0] ADDR_INTEN = 8'h15;
  localparam logic [7:0] ADDR_ROUTE = 8'h18;

  // Reset values
  localparam logic [7:0] RST_RANGE = 8'h00;
  localparam logic [7:0] RST_ODR = 8'h80;
  localparam logic [7:0] RST_PM = 8'h00;
  localparam logic [7:0] RST_INTEN = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'h00;

  // Field codes
  localparam logic [7:0] ODR_FIXED_BIT = 8'h80;
  localparam logic [7:0] RANGE_MAX_CODE = 8'h04;
  localparam logic [7:0] PM_CODE_NORMAL = 8'h00;
  localparam logic [7:0] PM_CODE_SUSPEND = 8'h80;
  localparam logic [7:0] PM_CODE_DEEP = 8'h20;
  localparam logic [7:0] SRST_KEY = 8'hB6;
  localparam logic [7:0] INTEN_ON = 8'h80;
  localparam logic [7:0] ROUTE_A = 8'h01;
  localparam logic [7:0] ROUTE_B = 8'h80;
  localparam logic [7:0] ROUTE_AB = 8'h81;
  localparam logic [6:0] STAT_LOW_ZERO = 7'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // Sample path: raw input is in units of the narrowest range
  localparam int RAW_W = 21;
  localparam int OUT_W = 16;
  localparam logic signed [RAW_W-1:0] SAT_MAX = 21'sh007FFF;
  localparam logic signed [RAW_W-1:0] SAT_MIN = -21'sh007FFF;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {PM_NORMAL, PM_SUSPEND, PM_DEEP} gcr_pm_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrEn;
    logic rdEn;
  } gcr_reg_req_t;

  typedef struct packed {
    logic [11:0] fullScaleDps;
    logic [10:0] odrHz;
    logic [9:0] bwHz;
  } gcr_cfg_t;

  ////////////////////////////////////////////////////////////////////////////
  // Decode tables; undefined codes fall back to code zero
  function automatic logic [11:0] gcr_full_scale(input logic [7:0] code);
    case (code)
      8'h01: gcr_full_scale = 12'h3E8;
      8'h02: gcr_full_scale = 12'h1F4;
      8'h03: gcr_full_scale = 12'h0FA;
      8'h04: gcr_full_scale = 12'h07D;
      default: gcr_full_scale = 12'h7D0;
    endcase
  endfunction : gcr_full_scale

  function automatic logic [10:0] gcr_odr_hz(input logic [6:0] code);
    case (code)
      7'h02: gcr_odr_hz = 11'h3E8;
      7'h03: gcr_odr_hz = 11'h190;
      7'h04, 7'h06: gcr_odr_hz = 11'h0C8;
      7'h05, 7'h07: gcr_odr_hz = 11'h064;
      default: gcr_odr_hz = 11'h7D0;
    endcase
  endfunction : gcr_odr_hz

  function automatic logic [9:0] gcr_bw_hz(input logic [6:0] code);
    case (code)
      7'h01: gcr_bw_hz = 10'h0E6;
      7'h02: gcr_bw_hz = 10'h074;
      7'h03: gcr_bw_hz = 10'h02F;
      7'h04: gcr_bw_hz = 10'h017;
      7'h05: gcr_bw_hz = 10'h00C;
      7'h06: gcr_bw_hz = 10'h040;
      7'h07: gcr_bw_hz = 10'h020;
      default: gcr_bw_hz = 10'h214;
    endcase
  endfunction : gcr_bw_hz

  // Sample period as a multiple of the fastest period
  function automatic logic [4:0] gcr_odr_div(input logic [6:0] code);
    case (code)
      7'h02: gcr_odr_div = 5'h02;
      7'h03: gcr_odr_div = 5'h05;
      7'h04, 7'h06: gcr_odr_div = 5'h0A;
      7'h05, 7'h07: gcr_odr_div = 5'h14;
      default: gcr_odr_div = 5'h01;
    endcase
  endfunction : gcr_odr_div

endpackage : gcr_pkg

// *** rtl/gcr_cycle_timer.sv ***
/*
  Loadable down-counter used for every delay in the bank.
  Assumes start and abort come from logic on the same clock.
*/
module gcr_cycle_timer
  import gcr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [gcr_pkg::TMR_W-1:0] load,
  // Status
  output logic busy,
  output logic done
);

  logic [TMR_W-1:0] count;

  // Done fires in the last counted cycle, unless a restart or an abort overrides it
  assign busy = (count != '0);
  assign done = (count == TMR_W'(1)) && !start && !abort;

  always_ff @(posedge mclk) begin
    if (sys_rst || abort) begin
      count <= '0;
    end else if (start) begin
      count <= load;
    end else if (busy) begin
      count <= count - TMR_W'(1);
    end
  end

endmodule : gcr_cycle_timer

// *** rtl/gcr_rate_config.sv ***
/*
  Configuration register bank of the angular-rate sensor: range, output rate and
  filter, power mode, soft reset and new-data interrupt with pin routing.
  Assumes the serial front end presents decoded one-cycle read and write strobes
  on mclk, and that rawRate is a same-clock sample in narrowest-range units.
*/
// Functional notes
// - Range codes 0 to 4 select 2000, 1000, 500, 250, 125 deg/s.
// - Bandwidth codes 0 to 7 map to fixed output rate and filter pairs.
// - Top bit of bandwidth register always reads one; writes to it ignored.
// - Power code 0x00 normal, 0x80 suspend, 0x20 deep suspend.
// - Writing 0xB6 to reset command starts soft reset; other values ignored.
// - After valid reset command wait 30 ms, then restore all defaults.
// - Soft reset is accepted in every power mode, suspends included.
// - Interrupt control 0x00, the default, raises no new-data interrupt.
// - Interrupt control 0x80 raises new-data interrupt on every new sample.
// - New-data flag clears itself 280 to 400 us after being set.
// - Routing 0x01 pin A, 0x80 pin B, 0x81 both, 0x00 none.
module gcr_rate_config #(
  parameter int unsigned SRST_CYCLES = gcr_pkg::SRST_WAIT_CYCLES,
  parameter int unsigned DRDY_CYCLES = gcr_pkg::DRDY_HOLD_CYCLES,
  parameter int unsigned ODR_BASE = gcr_pkg::ODR_BASE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire gcr_pkg::gcr_reg_req_t regReq,
  output logic [7:0] regRdData,
  // Sample path
  input wire logic signed [gcr_pkg::RAW_W-1:0] rawRate,
  output logic signed [gcr_pkg::OUT_W-1:0] rateSample,
  output logic sampleValid,
  // Configuration and status
  output gcr_pkg::gcr_cfg_t cfg,
  output logic sensorActive,
  output logic resetPending,
  // Interrupt pins, active high push-pull
  output logic irqPinA,
  output logic irqPinB
);
  import gcr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and decode
  typedef enum logic {RS_IDLE, RS_WAIT} gcr_rst_state_t;

  logic [7:0] rangeReg;
  logic [7:0] odrReg;
  logic [7:0] pmReg;
  logic [7:0] intEnReg;
  logic [7:0] routeReg;
  logic drdy;
  gcr_rst_state_t rsState;
  gcr_rst_state_t next_rsState;

  wire wrRange = regReq.wrEn && (regReq.addr == ADDR_RANGE);
  wire wrOdr = regReq.wrEn && (regReq.addr == ADDR_ODR);
  wire wrPm = regReq.wrEn && (regReq.addr == ADDR_PM);
  wire wrSrst = regReq.wrEn && (regReq.addr == ADDR_SRST);
  wire wrIntEn = regReq.wrEn && (regReq.addr == ADDR_INTEN);
  wire wrRoute = regReq.wrEn && (regReq.addr == ADDR_ROUTE);
  wire srstCmd = wrSrst && (regReq.wrData == SRST_KEY);
  wire srstDone;
  wire srstBusy;
  wire restoreNow = srstDone && (rsState == RS_WAIT);
  wire loadDefaults = sys_rst || restoreNow;

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset sequencer; the command is decoded regardless of power mode
  always_comb begin
    next_rsState = rsState;
    case (rsState)
      RS_IDLE: if (srstCmd) next_rsState = RS_WAIT;
      RS_WAIT: if (restoreNow) next_rsState = RS_IDLE;
      default: next_rsState = RS_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsState <= RS_IDLE;
    end else begin
      rsState <= next_rsState;
    end
  end

  // A repeated command while waiting restarts the 30 ms wait
  gcr_cycle_timer u_srst_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(srstCmd),
    .abort(1'b0),
    .load(TMR_W'(SRST_CYCLES)),
    .busy(srstBusy),
    .done(srstDone)
  );

  assign resetPending = (rsState == RS_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge mclk) begin
    if (loadDefaults) begin
      rangeReg <= RST_RANGE;
      odrReg <= RST_ODR;
      pmReg <= RST_PM;
      intEnReg <= RST_INTEN;
      routeReg <= RST_ROUTE;
    end else begin
      if (wrRange) rangeReg <= regReq.wrData;
      if (wrOdr) odrReg <= regReq.wrData | ODR_FIXED_BIT;
      if (wrPm) pmReg <= regReq.wrData;
      if (wrIntEn) intEnReg <= regReq.wrData;
      if (wrRoute) routeReg <= regReq.wrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode; unknown codes behave as normal. The bank does not police the
  // suspend-to-deep order, that is up to the host
  gcr_pm_t pmState;
  assign pmState = (pmReg == PM_CODE_SUSPEND) ? PM_SUSPEND :
                   (pmReg == PM_CODE_DEEP) ? PM_DEEP : PM_NORMAL;
  wire sampling = (pmState == PM_NORMAL) && (rsState == RS_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Output data rate tick; a rate change takes effect at the next period
  wire [6:0] odrCode = odrReg[6:0];
  wire [TMR_W-1:0] odrLoad = TMR_W'(ODR_BASE * gcr_odr_div(odrCode) - 1);
  wire odrBusy;
  wire sampleTick;

  gcr_cycle_timer u_odr_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(sampling && !odrBusy),
    .abort(!sampling),
    .load(odrLoad),
    .busy(odrBusy),
    .done(sampleTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sample scaling: shift right from the narrowest range, then saturate
  wire rangeValid = (rangeReg <= RANGE_MAX_CODE);
  wire [2:0] rangeCode = rangeValid ? rangeReg[2:0] : 3'h0;
  wire [2:0] shiftAmt = RANGE_MAX_CODE[2:0] - rangeCode;
  wire signed [RAW_W-1:0] shifted = rawRate >>> shiftAmt;
  wire signed [RAW_W-1:0] clipped = (shifted > SAT_MAX) ? SAT_MAX :
                                    (shifted < SAT_MIN) ? SAT_MIN : shifted;

  always_ff @(posedge mclk) begin
    if (loadDefaults) begin
      rateSample <= '0;
      sampleValid <= 1'b0;
    end else begin
      sampleValid <= sampleTick;
      if (sampleTick) rateSample <= clipped[OUT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // New-data flag; a fresh sample in the clearing cycle re-arms it
  wire drdySet = sampleTick && (intEnReg == INTEN_ON);
  wire drdyDone;
  wire routeA = (routeReg == ROUTE_A) || (routeReg == ROUTE_AB);
  wire routeB = (routeReg == ROUTE_B) || (routeReg == ROUTE_AB);

  gcr_cycle_timer u_drdy_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(drdySet),
    .abort(restoreNow),
    .load(TMR_W'(DRDY_CYCLES)),
    .busy(),
    .done(drdyDone)
  );

  always_ff @(posedge mclk) begin
    if (loadDefaults) begin
      drdy <= 1'b0;
      irqPinA <= 1'b0;
      irqPinB <= 1'b0;
    end else begin
      if (drdySet) drdy <= 1'b1;
      else if (drdyDone) drdy <= 1'b0;
      irqPinA <= drdy && routeA;
      irqPinB <= drdy && routeB;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path and decoded configuration; unmapped and write-only read zero
  wire [7:0] rdMux =
    (regReq.addr == ADDR_RANGE) ? rangeReg :
    (regReq.addr == ADDR_ODR) ? odrReg :
    (regReq.addr == ADDR_PM) ? pmReg :
    (regReq.addr == ADDR_INTEN) ? intEnReg :
    (regReq.addr == ADDR_ROUTE) ? routeReg :
    (regReq.addr == ADDR_STAT) ? {drdy, STAT_LOW_ZERO} : READ_NONE;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdData <= READ_NONE;
      cfg <= '0;
      sensorActive <= 1'b0;
    end else begin
      if (regReq.rdEn) regRdData <= rdMux;
      cfg.fullScaleDps <= gcr_full_scale(rangeReg);
      cfg.odrHz <= gcr_odr_hz(odrCode);
      cfg.bwHz <= gcr_bw_hz(odrCode);
      sensorActive <= sampling;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [TMR_W-1:0] drdyAge;
  always_ff @(posedge mclk) begin
    if (loadDefaults) drdyAge <= '0;
    else if (drdySet) drdyAge <= TMR_W'(1);
    else if (drdy) drdyAge <= drdyAge + TMR_W'(1);
    else drdyAge <= '0;
  end

  sequence s_flag_raise;
    drdySet ##1 drdy;
  endsequence

  sequence s_flag_to_pin;
    drdy && routeA && routeB ##1 irqPinA && irqPinB;
  endsequence

  chk_range_decode_mid: assert property (@(posedge mclk) disable iff (sys_rst)
    (rangeReg == 8'h02) && $stable(rangeReg) |=> cfg.fullScaleDps == 12'h1F4)
    else $error("full scale not 500 for range code 2");

  chk_scale_narrow: assert property (@(posedge mclk) disable iff (sys_rst)
    sampleTick && (rangeReg == RANGE_MAX_CODE) && (rawRate <= SAT_MAX) && (rawRate >= SAT_MIN)
    |=> rateSample == $past(rawRate[OUT_W-1:0]))
    else $error("narrowest range does not pass raw counts");

  chk_bw_decode_pair: assert property (@(posedge mclk) disable iff (sys_rst)
    (odrCode == 7'h03) && $stable(odrReg) |=> (cfg.odrHz == 11'h190) && (cfg.bwHz == 10'h02F))
    else $error("bandwidth code 3 decode wrong");

  chk_odr_top_bit: assert property (@(posedge mclk) disable iff (sys_rst)
    regReq.rdEn && (regReq.addr == ADDR_ODR) |=> regRdData[7])
    else $error("bandwidth top bit read as zero");

  chk_suspend_no_sample: assert property (@(posedge mclk) disable iff (sys_rst)
    (pmReg == PM_CODE_SUSPEND) || (pmReg == PM_CODE_DEEP) |-> !sampleTick)
    else $error("sample produced in suspend");

  chk_reset_key_only: assert property (@(posedge mclk) disable iff (sys_rst)
    wrSrst && (regReq.wrData != SRST_KEY) && !resetPending |=> !resetPending)
    else $error("soft reset started by wrong key");

  chk_defaults_restored: assert property (@(posedge mclk) disable iff (sys_rst)
    restoreNow |=> (rangeReg == RST_RANGE) && (odrReg == RST_ODR) && (pmReg == RST_PM)
      && (intEnReg == RST_INTEN) && (routeReg == RST_ROUTE) && !resetPending)
    else $error("defaults not restored after soft reset");

  chk_reset_in_deep: assert property (@(posedge mclk) disable iff (sys_rst)
    srstCmd && (pmReg == PM_CODE_DEEP) |=> resetPending ##1 srstBusy)
    else $error("soft reset refused in deep suspend");

  chk_flag_needs_enable: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(drdy) |-> $past(intEnReg) == INTEN_ON)
    else $error("new-data flag raised while disabled");

  chk_flag_on_sample: assert property (@(posedge mclk) disable iff (sys_rst)
    drdySet |-> s_flag_raise)
    else $error("new-data flag missed a sample");

  chk_flag_self_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(drdy) && !$past(loadDefaults) |-> $past(drdyAge) == TMR_W'(DRDY_CYCLES))
    else $error("new-data flag hold time wrong");

  chk_pin_both: assert property (@(posedge mclk) disable iff (sys_rst)
    drdy && routeA && routeB && !$past(loadDefaults) |-> s_flag_to_pin)
    else $error("flag not routed to both pins");

  chk_odr_cadence: assert property (@(posedge mclk) disable iff (sys_rst)
    sampleTick && (odrCode == 7'h00) && $stable(odrReg) |=> !sampleTick [*8])
    else $error("samples closer than the selected rate");

endmodule : gcr_rate_config

// *** dv/gcr_host_model.sv ***
/*
  Host-side model of the register port: single byte writes and reads.
  Assumes every call starts 2 ns after a rising mclk edge and returns likewise.
*/
module gcr_host_model
  import gcr_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Register port
  output gcr_pkg::gcr_reg_req_t regReq,
  input wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pmNow;

  initial begin
    regReq = '0;
    pmNow = PM_CODE_NORMAL;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle lines show inverted junk so stale values are never mistaken for data
  task automatic drop_port();
    regReq.wrEn = 1'b0;
    regReq.rdEn = 1'b0;
    regReq.addr = ~regReq.addr;
    regReq.wrData = ~regReq.wrData;
    @(posedge mclk);
    #2;
  endtask : drop_port

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regReq.addr = a;
    regReq.wrData = d;
    regReq.wrEn = 1'b1;
    @(posedge mclk);
    #2;
    if (a == ADDR_PM) pmNow = d;
    if (a == ADDR_SRST && d == SRST_KEY) pmNow = PM_CODE_NORMAL;
    drop_port();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regReq.addr = a;
    regReq.rdEn = 1'b1;
    @(posedge mclk);
    #2;
    d = regRdData;
    drop_port();
  endtask : rd

  // Suspend states are only left or entered through normal mode
  task automatic set_pm(input logic [7:0] code);
    if (pmNow != PM_CODE_NORMAL && code != PM_CODE_NORMAL) wr(ADDR_PM, PM_CODE_NORMAL);
    wr(ADDR_PM, code);
  endtask : set_pm

endmodule : gcr_host_model

// *** dv/tb_top.sv ***
/*
  Self-checking bench for the rate-sensor configuration bank.
  Assumes shortened counts: reset wait 50, flag hold 20, base period 40 cycles.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import gcr_pkg::*;

  localparam int SRST = 50;
  localparam int DRDY = 20;
  localparam int BASE = 40;
  localparam logic signed [20:0] RAW_T = -21'sh000BB8;

  logic mclk;
  logic sys_rst;
  gcr_reg_req_t regReq;
  logic [7:0] regRdData;
  logic signed [20:0] rawRate;
  logic signed [15:0] rateSample;
  logic sampleValid;
  gcr_cfg_t cfg;
  logic sensorActive;
  logic resetPending;
  logic irqPinA;
  logic irqPinB;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  gcr_rate_config #(.SRST_CYCLES(SRST), .DRDY_CYCLES(DRDY), .ODR_BASE(BASE)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData),
    .rawRate(rawRate), .rateSample(rateSample), .sampleValid(sampleValid), .cfg(cfg),
    .sensorActive(sensorActive), .resetPending(resetPending),
    .irqPinA(irqPinA), .irqPinB(irqPinB)
  );

  gcr_host_model host (.mclk(mclk), .regReq(regReq), .regRdData(regRdData));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic step(input int n);
    repeat (n) begin
      @(posedge mclk);
      #2;
    end
  endtask : step

  // Bounded wait for the next sample pulse; k is the cycles waited
  task automatic wait_sv(output int k);
    k = 0;
    while (sampleValid !== 1'b1 && k < 2000) begin
      step(1);
      k++;
    end
    chk8({7'h00, sampleValid}, 8'h01);
  endtask : wait_sv

  // Counts sample pulses over a window longer than two base periods
  task automatic quiet(output int n);
    n = 0;
    repeat (100) begin
      step(1);
      if (sampleValid === 1'b1) n++;
    end
  endtask : quiet

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    logic [7:0] d;
    logic [7:0] adr [7] = '{8'h0F, 8'h10, 8'h11, 8'h15, 8'h18, 8'h14, 8'h20};
    logic [7:0] exp [7] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      host.rd(adr[i], d);
      chk8(d, exp[i]);
    end
    chk16(16'(cfg.fullScaleDps), 16'h07D0);
    chk16(16'(cfg.odrHz), 16'h07D0);
    chk16(16'(cfg.bwHz), 16'h0214);
  endtask : t_defaults

  task automatic t_range();
    logic [7:0] d;
    int k;
    logic [15:0] fs [5] = '{16'h07D0, 16'h03E8, 16'h01F4, 16'h00FA, 16'h007D};
    for (int c = 0; c < 5; c++) begin
      host.wr(8'h0F, 8'(c));
      host.rd(8'h0F, d);
      chk8(d, 8'(c));
      chk16(16'(cfg.fullScaleDps), fs[c]);
      wait_sv(k);
      step(1);
      wait_sv(k);
      chk16(rateSample, 16'(RAW_T >>> (4 - c)));
    end
    // Out-of-range input in the narrowest range must clip
    rawRate = 21'sh0FFFFF;
    wait_sv(k);
    step(1);
    wait_sv(k);
    chk16(rateSample, 16'h7FFF);
    rawRate = RAW_T;
  endtask : t_range

  task automatic t_odr();
    logic [7:0] d;
    int k;
    logic [15:0] hz [8] = '{16'h07D0, 16'h07D0, 16'h03E8, 16'h0190,
                            16'h00C8, 16'h0064, 16'h00C8, 16'h0064};
    logic [15:0] bw [8] = '{16'h0214, 16'h00E6, 16'h0074, 16'h002F,
                            16'h0017, 16'h000C, 16'h0040, 16'h0020};
    int dv [8] = '{1, 1, 2, 5, 10, 20, 10, 20};
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h10, 8'(c));
      host.rd(8'h10, d);
      chk8(d, 8'h80 | 8'(c));
      chk16(16'(cfg.odrHz), hz[c]);
      chk16(16'(cfg.bwHz), bw[c]);
      wait_sv(k);
      step(1);
      wait_sv(k);
      chk16(16'(k + 1), 16'(BASE * dv[c]));
    end
  endtask : t_odr

  // Pins high for exactly the hold time, then low before the next sample
  task automatic t_irq();
    logic [7:0] d;
    int k;
    logic [7:0] rt [4] = '{8'h00, 8'h01, 8'h80, 8'h81};
    host.wr(8'h10, 8'h00);
    host.wr(8'h15, 8'h80);
    for (int r = 0; r < 4; r++) begin
      host.wr(8'h18, rt[r]);
      wait_sv(k);
      step(1);
      chk8({6'h00, irqPinB, irqPinA}, {6'h00, rt[r][7], rt[r][0]});
      step(DRDY - 1);
      chk8({6'h00, irqPinB, irqPinA}, {6'h00, rt[r][7], rt[r][0]});
      step(1);
      chk8({6'h00, irqPinB, irqPinA}, 8'h00);
    end
    // Status bit seen while the flag stands, then gone after the hold
    wait_sv(k);
    host.rd(8'h0A, d);
    chk8(d, 8'h80);
    step(DRDY);
    host.rd(8'h0A, d);
    chk8(d, 8'h00);
    host.wr(8'h15, 8'h00);
    wait_sv(k);
    step(1);
    chk8({6'h00, irqPinB, irqPinA}, 8'h00);
  endtask : t_irq

  task automatic t_power();
    logic [7:0] d;
    int n;
    logic [7:0] adr [5] = '{8'h0F, 8'h10, 8'h11, 8'h15, 8'h18};
    logic [7:0] exp [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    host.set_pm(8'h80);
    step(1);
    chk8({7'h00, sensorActive}, 8'h00);
    quiet(n);
    chk16(16'(n), 16'h0000);
    host.set_pm(8'h20);
    step(1);
    chk8({7'h00, sensorActive}, 8'h00);
    quiet(n);
    chk16(16'(n), 16'h0000);
    host.wr(8'h14, 8'h55);
    chk8({7'h00, resetPending}, 8'h00);
    host.rd(8'h11, d);
    chk8(d, 8'h20);
    host.wr(8'h14, 8'hB6);
    n = 1;
    while (resetPending === 1'b1 && n < 1000) begin
      n++;
      step(1);
    end
    chk16(16'(n), 16'(SRST));
    for (int i = 0; i < 5; i++) begin
      host.rd(adr[i], d);
      chk8(d, exp[i]);
    end
    chk8({7'h00, sensorActive}, 8'h01);
    quiet(n);
    chk8(8'(n > 0), 8'h01);
  endtask : t_power

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 40000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    sys_rst = 1'b1;
    rawRate = RAW_T;
    repeat (2) @(posedge mclk);
    #2;
    sys_rst = 1'b0;
    step(1);
    t_defaults();
    t_range();
    t_odr();
    t_irq();
    t_power();
    end_of_test();
  end

endmodule : tb_top
